// ### wdt_pkg.sv
// Constants and carrier types for the system watchdog timer
package wdt_pkg;
    localparam int          WDT_CNT_W        = 16;
    localparam int          WDT_PRESC_W      = 14;
    localparam int          WDT_DIV_SLOW     = 16384;
    localparam int          WDT_DIV_FAST     = 256;
    localparam logic        WDT_SEL_FAST     = 1'h0;
    localparam logic        WDT_SEL_SLOW     = 1'h1;
    // Fast divide with 256 ticks left gives 6.55 ms at 10 MHz
    localparam logic        WDT_SEL_RST      = 1'h0;
    localparam logic [15:0] WDT_RELOAD_RST   = 16'hFF00;
    localparam logic [15:0] WDT_CNT_ONES     = 16'hFFFF;
    localparam logic [13:0] WDT_PRESC_ZERO   = 14'h0000;
    // Gap between prewarning and reset request, in microseconds
    localparam int          WDT_WARN_US      = 10;
    localparam int          WDT_CLK_MHZ      = 10;
    localparam int          WDT_WARN_CYCLES  = WDT_WARN_US * WDT_CLK_MHZ;
    localparam int          WDT_WARN_W       = 8;

    typedef struct packed {
        logic service;
        logic wd_off;
        logic wd_on;
    } wdt_cmd_t;

    typedef struct packed {
        logic        load;
        logic        presc_sel;
        logic [15:0] reload;
    } wdt_cfg_t;

    typedef enum logic [1:0] {
        WDT_ST_RUN,
        WDT_ST_OFF,
        WDT_ST_WARN,
        WDT_ST_RESET
    } wdt_state_t;
endpackage : wdt_pkg

// ### wdt_system_watchdog.sv
// System watchdog timer: prescaler, 16-bit counter, prewarning and reset request
// What this block does
// - After application reset the watchdog is counting and monitoring.
// - Off instruction stops monitoring, on instruction resumes it, except once the prewarning phase has begun.
// - Counter is 16 bits, advanced through prescaler dividing by 16384 or 256.
// - Service loads counter from reload value and clears the prescaler, except once the prewarning phase has begun.
// - Overflow raises prewarning interrupt first, then a reset request.
// - Prescaler and reload span about 3.2 us to 13.4 s at 80 MHz.
// - Reset defaults give about 6.5 ms interval at 10 MHz.
`timescale 1ns/1ps
module wdt_system_watchdog
    import wdt_pkg::*;
#(
    parameter int DIV_SLOW = WDT_DIV_SLOW,
    parameter int DIV_FAST = WDT_DIV_FAST,
    parameter int WARN_CYCLES = WDT_WARN_CYCLES
) (
    input  wire logic                 clk_sys_in,
    input  wire logic                 rst_in,
    input  wire wdt_cmd_t             cmd_in,
    input  wire wdt_cfg_t             cfg_in,
    output logic                      prewarn_irq_out,
    output logic                      reset_req_out,
    output logic                      monitoring_out,
    output logic [WDT_CNT_W-1:0]      count_out
);
    wdt_state_t             state_reg,  state_next;
    logic [WDT_CNT_W-1:0]   cnt_reg,    cnt_next;
    logic [WDT_PRESC_W-1:0] presc_reg,  presc_next;
    logic [WDT_CNT_W-1:0]   reload_reg, reload_next;
    logic                   sel_reg,    sel_next;
    logic [WDT_WARN_W-1:0]  warn_reg,   warn_next;
    logic                   irq_reg,    irq_next;
    logic                   rreq_reg,   rreq_next;
    logic                   mon_reg,    mon_next;
    logic                   tick;
    logic                   overflow;

    // Terminal prescaler count for the selected divide
    function automatic logic [WDT_PRESC_W-1:0] presc_limit(input logic sel);
        presc_limit = (sel == WDT_SEL_SLOW) ? WDT_PRESC_W'(DIV_SLOW - 1)
                                            : WDT_PRESC_W'(DIV_FAST - 1);
    endfunction : presc_limit

    assign tick     = (presc_reg == presc_limit(sel_reg));
    assign overflow = tick && (cnt_reg == WDT_CNT_ONES);

    always_comb begin
        state_next  = state_reg;
        cnt_next    = cnt_reg;
        presc_next  = presc_reg;
        reload_next = reload_reg;
        sel_next    = sel_reg;
        warn_next   = warn_reg;
        irq_next    = 1'b0;
        rreq_next   = rreq_reg;
        // Reload value takes effect at the next service, prescaler select on the next cycle
        if (cfg_in.load) begin
            reload_next = cfg_in.reload;
            sel_next    = cfg_in.presc_sel;
        end
        unique case (state_reg)
            WDT_ST_RUN: begin
                if (cmd_in.wd_off) begin
                    state_next = WDT_ST_OFF;
                end else if (cmd_in.service) begin
                    cnt_next   = reload_reg;
                    presc_next = WDT_PRESC_ZERO;
                end else if (overflow) begin
                    state_next = WDT_ST_WARN;
                    irq_next   = 1'b1;
                    warn_next  = WDT_WARN_W'(WARN_CYCLES - 1);
                    cnt_next   = cnt_reg + 1'b1;
                    presc_next = WDT_PRESC_ZERO;
                end else if (tick) begin
                    cnt_next   = cnt_reg + 1'b1;
                    presc_next = WDT_PRESC_ZERO;
                end else begin
                    presc_next = presc_reg + 1'b1;
                end
            end
            WDT_ST_OFF: begin
                // Counter and prescaler hold while off unless a service reloads them
                if (cmd_in.wd_on) begin
                    state_next = WDT_ST_RUN;
                end else if (cmd_in.service) begin
                    cnt_next   = reload_reg;
                    presc_next = WDT_PRESC_ZERO;
                end
            end
            WDT_ST_WARN: begin
                // Service cannot cancel a pending reset once warned
                if (warn_reg == '0) begin
                    state_next = WDT_ST_RESET;
                    rreq_next  = 1'b1;
                end else begin
                    warn_next = warn_reg - 1'b1;
                end
            end
            WDT_ST_RESET: begin
                rreq_next = 1'b1;
            end
        endcase
        // Registered so the monitoring flag never glitches on state decode
        mon_next = (state_next != WDT_ST_OFF);
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            state_reg  <= WDT_ST_RUN;
            cnt_reg    <= WDT_RELOAD_RST;
            presc_reg  <= WDT_PRESC_ZERO;
            reload_reg <= WDT_RELOAD_RST;
            sel_reg    <= WDT_SEL_RST;
            warn_reg   <= '0;
            irq_reg    <= 1'b0;
            rreq_reg   <= 1'b0;
            mon_reg    <= 1'b1;
        end else begin
            state_reg  <= state_next;
            cnt_reg    <= cnt_next;
            presc_reg  <= presc_next;
            reload_reg <= reload_next;
            sel_reg    <= sel_next;
            warn_reg   <= warn_next;
            irq_reg    <= irq_next;
            rreq_reg   <= rreq_next;
            mon_reg    <= mon_next;
        end
    end

    assign prewarn_irq_out = irq_reg;
    assign reset_req_out   = rreq_reg;
    assign monitoring_out  = mon_reg;
    assign count_out       = cnt_reg;

    // Checks
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    a_reset_runs: assert property (@(posedge clk_sys_in) disable iff (1'b0)
        rst_in |=> state_reg == WDT_ST_RUN && cnt_reg == WDT_RELOAD_RST)
        else $error("watchdog not running after reset");
    a_defaults: assert property (@(posedge clk_sys_in) disable iff (1'b0)
        rst_in |=> reload_reg == WDT_RELOAD_RST && sel_reg == WDT_SEL_FAST)
        else $error("wrong reset defaults");
    a_off_stops: assert property (state_reg == WDT_ST_RUN && cmd_in.wd_off
        |=> state_reg == WDT_ST_OFF ##1 $stable(presc_reg))
        else $error("off request did not stop counting");
    a_on_resumes: assert property (state_reg == WDT_ST_OFF && cmd_in.wd_on
        |=> state_reg == WDT_ST_RUN)
        else $error("on request did not resume");
    a_service_load: assert property ((state_reg == WDT_ST_RUN || state_reg == WDT_ST_OFF)
        && cmd_in.service && !cmd_in.wd_off && !cmd_in.wd_on
        |=> cnt_reg == $past(reload_reg) && presc_reg == WDT_PRESC_ZERO)
        else $error("service did not reload");
    a_presc_wrap: assert property (state_reg == WDT_ST_RUN && !cmd_in.service
        && !cmd_in.wd_off && presc_reg == presc_limit(sel_reg)
        |=> presc_reg == WDT_PRESC_ZERO)
        else $error("prescaler wrap wrong");
    a_count_inc: assert property (state_reg == WDT_ST_RUN && tick && !cmd_in.service
        && !cmd_in.wd_off |=> cnt_reg == $past(cnt_reg) + 1'b1)
        else $error("counter did not advance on tick");
    a_warn_first: assert property (state_reg == WDT_ST_RUN && overflow
        && !cmd_in.service && !cmd_in.wd_off |=> prewarn_irq_out && !reset_req_out)
        else $error("prewarning missing at overflow");
    a_reset_after: assert property ($rose(prewarn_irq_out)
        |-> !reset_req_out [*2] ##[0:300] reset_req_out)
        else $error("reset request not issued after prewarning");

    // Prewarning is a pulse, the reset request a level
    a_irq_pulse: assert property (prewarn_irq_out |=> !prewarn_irq_out)
        else $error("prewarning longer than one cycle");

    a_req_sticky: assert property (reset_req_out |=> reset_req_out)
        else $error("reset request dropped before reset");

    a_req_needs_warn: assert property ($rose(reset_req_out)
        |-> $past(state_reg) == WDT_ST_WARN)
        else $error("reset request without prewarning phase");

    // Once warned, no command may bring the counter back
    a_warn_locked: assert property (state_reg == WDT_ST_WARN
        |=> state_reg == WDT_ST_WARN || state_reg == WDT_ST_RESET)
        else $error("warning phase left without reset");

    a_off_holds: assert property (state_reg == WDT_ST_OFF && !cmd_in.service
        |=> $stable(cnt_reg))
        else $error("counter moved while off");

    a_mon_follows: assert property (monitoring_out == (state_reg != WDT_ST_OFF))
        else $error("monitoring flag disagrees with state");

    a_mon_after_reset: assert property (@(posedge clk_sys_in) disable iff (1'b0)
        rst_in |=> monitoring_out)
        else $error("monitoring off after reset");

    a_cnt_hold: assert property (state_reg == WDT_ST_RUN && !tick && !cmd_in.service
        && !cmd_in.wd_off |=> $stable(cnt_reg))
        else $error("counter moved without a tick");

    c_service: cover property (cmd_in.service && state_reg == WDT_ST_RUN);
    c_off_service: cover property (cmd_in.service && state_reg == WDT_ST_OFF);
    c_off_on: cover property (cmd_in.wd_off ##[1:20] cmd_in.wd_on);
    c_overflow: cover property ($rose(prewarn_irq_out));
    c_reset: cover property ($rose(reset_req_out));
endmodule : wdt_system_watchdog

// ### wdt_core_model.sv
// Core-side model issuing service, off and on strobes
`timescale 1ns/1ps
module wdt_core_model
    import wdt_pkg::*;
(
    input  wire logic [1:0] op_in,
    output wdt_cmd_t        cmd_out
);
    // One-hot decode: two strobes can never meet in one cycle
    always_comb begin
        cmd_out.service = (op_in == 2'h1);
        cmd_out.wd_off  = (op_in == 2'h2);
        cmd_out.wd_on   = (op_in == 2'h3);
    end
endmodule : wdt_core_model

// ### system_watchdog_timer_test.sv
// Self-checking bench for the system watchdog timer
`timescale 1ns/1ps
module system_watchdog_timer_test;
    import wdt_pkg::*;
    localparam int DS = 32;
    localparam int DF = 4;
    localparam int WC = 4;
    logic        clk_sys_in = 1'h0;
    logic        rst_in     = 1'h1;
    logic [1:0]  op         = 2'h0;
    wdt_cfg_t    cfg        = '0;
    wdt_cmd_t    cmd;
    logic        warn, req, mon;
    logic [15:0] count;
    int          failures   = 0;
    int          checks     = 0;
    logic [31:0] rng        = 32'h000005CF;
    wdt_core_model i_core (.op_in(op), .cmd_out(cmd));
    wdt_system_watchdog #(.DIV_SLOW(DS), .DIV_FAST(DF), .WARN_CYCLES(WC)) i_dut (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .cmd_in(cmd), .cfg_in(cfg),
        .prewarn_irq_out(warn), .reset_req_out(req), .monitoring_out(mon),
        .count_out(count));
    always #50 clk_sys_in = ~clk_sys_in;
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift
    function automatic int interval(input logic [15:0] r, input logic sel);
        return (32'h10000 - r) * (sel ? DS : DF);
    endfunction : interval
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check
    task automatic report_and_stop();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic do_reset();
        @(posedge clk_sys_in) rst_in <= 1'h1;
        repeat (8) @(posedge clk_sys_in);
        rst_in <= 1'h0;
        #1;
    endtask : do_reset
    task automatic strobe(input logic [1:0] o);
        @(posedge clk_sys_in) op <= o;
        @(posedge clk_sys_in) op <= 2'h0;
        #1;
    endtask : strobe
    task automatic cfg_load(input logic sel, input logic [15:0] r);
        @(posedge clk_sys_in) cfg <= '{1'h1, sel, r};
        @(posedge clk_sys_in) cfg.load <= 1'h0;
    endtask : cfg_load
    // Counts settled cycles until the prewarning, capped at lim
    task automatic wait_warn(output int n, input int lim);
        n = 0;
        while (warn !== 1'h1 && n < lim) begin
            @(posedge clk_sys_in);
            #1;
            n++;
        end
    endtask : wait_warn
    task automatic check_tail();
        int n;
        @(posedge clk_sys_in);
        #1;
        check("warn_pulse", warn, 1'h0);
        check("req_early", req, 1'h0);
        wait_warn(n, 0);
        for (n = 1; req !== 1'h1 && n < 300; n++) begin
            @(posedge clk_sys_in);
            #1;
        end
        check("req_delay", n, WC);
    endtask : check_tail
    initial begin
        #(100 * 100000);
        failures++;
        report_and_stop();
    end
    initial begin
        int          n;
        logic [15:0] r;
        do_reset();
        check("count_rst", count, WDT_RELOAD_RST);
        check("mon_rst", mon, 1'h1);
        wait_warn(n, 70000);
        check("default_span", n, interval(WDT_RELOAD_RST, WDT_SEL_RST));
        check_tail();
        for (int i = 0; i < 6; i++) begin
            rng = xorshift(rng);
            // Shortest corner still outlasts the random service delay
            r = (i < 2) ? 16'hFFFE : (16'hFF80 | {10'h000, rng[5:0]});
            do_reset();
            check("mon_again", mon, 1'h1);
            cfg_load(i[0], r);
            strobe(2'h1);
            check("reload", count, r);
            repeat (rng[9:8]) @(posedge clk_sys_in);
            if (i > 3) begin
                strobe(2'h2);
                check("mon_off", mon, 1'h0);
                wait_warn(n, interval(r, i[0]) + 8);
                check("off_quiet", n, interval(r, i[0]) + 8);
                strobe(2'h3);
                check("mon_on", mon, 1'h1);
            end
            strobe(2'h1);
            check("reload_again", count, r);
            wait_warn(n, 70000);
            check("span", n, interval(r, i[0]));
            check_tail();
        end
        report_and_stop();
    end
endmodule : system_watchdog_timer_test
